// *** core/cpf_config_bank.sv ***
// configuration, protection and debug option bank with an axi4-lite slave
// assumes stack_full and stack_underflow come from logic on clk_sys
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
module cpf_config_bank #(
  parameter bit SMALL_MEM = 1'b0
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic [cpf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [cpf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       stack_full,
  input  wire logic                       stack_underflow,
  output var  cpf_pkg::cpf_opt_t          opt,
  output var  cpf_pkg::cpf_prot_t         prot,
  output var  logic                       debug_pins_dedicated,
  output var  logic                       stack_reset_req,
  output var  logic                       stack_fault_flag
);

  function automatic logic mapped(input logic [cpf_pkg::ADDR_W-1:0] a);
    mapped = (a == cpf_pkg::OFF_DBG) || (a == cpf_pkg::OFF_RDP) ||
             (a == cpf_pkg::OFF_BEP) || (a == cpf_pkg::OFF_WRP) ||
             (a == cpf_pkg::OFF_STS);
  endfunction

  logic [7:0]                 dbg_ff;
  logic [7:0]                 rdp_ff;
  logic [7:0]                 bep_ff;
  logic [7:0]                 wrp_ff;
  logic [7:0]                 sts_ff;
  logic                       aw_held_ff;
  logic                       w_held_ff;
  logic [cpf_pkg::ADDR_W-1:0] aw_addr_ff;
  logic [7:0]                 w_data_ff;
  logic                       w_lane0_ff;
  logic                       awready_ff;
  logic                       wready_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       arready_ff;
  logic                       rvalid_ff;
  logic [31:0]                rdata_ff;
  logic [1:0]                 rresp_ff;
  cpf_pkg::cpf_opt_t          opt_ff;
  cpf_pkg::cpf_prot_t         prot_ff;
  logic                       dbg_pins_ff;
  logic                       stk_rst_ff;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic nxt_aw_held;
  logic nxt_w_held;
  logic nxt_bvalid;
  logic nxt_rvalid;
  logic stack_fault;
  logic wr_en;

  assign aw_hs       = s_axi_awvalid && awready_ff;
  assign w_hs        = s_axi_wvalid && wready_ff;
  assign ar_hs       = s_axi_arvalid && arready_ff;
  assign wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_en       = wr_fire && w_lane0_ff;
  assign stack_fault = stack_full || stack_underflow;

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_rvalid  = rvalid_ff;
    if (aw_hs) begin
      nxt_aw_held = 1'b1;
    end
    if (w_hs) begin
      nxt_w_held = 1'b1;
    end
    if (wr_fire) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_rvalid = 1'b1;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channels, taken in either order
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff  <= !nxt_w_held && !nxt_bvalid;
      if (aw_hs) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_ff  <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= cpf_pkg::RESP_OKAY;
    end else begin
      bvalid_ff <= nxt_bvalid;
      if (wr_fire) begin
        bresp_ff <= mapped(aw_addr_ff) ? cpf_pkg::RESP_OKAY : cpf_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= cpf_pkg::RESP_OKAY;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_hs) begin
        rresp_ff <= mapped(s_axi_araddr) ? cpf_pkg::RESP_OKAY : cpf_pkg::RESP_SLVERR;
        unique case (s_axi_araddr)
          cpf_pkg::OFF_DBG: rdata_ff <= {24'h00_0000, dbg_ff & cpf_pkg::DBG_MASK};
          cpf_pkg::OFF_RDP: rdata_ff <= {24'h00_0000, rdp_ff & cpf_pkg::RDP_MASK};
          cpf_pkg::OFF_BEP: rdata_ff <= {24'h00_0000, bep_ff & cpf_pkg::BEP_MASK};
          cpf_pkg::OFF_WRP: rdata_ff <= {24'h00_0000, wrp_ff & cpf_pkg::WRP_MASK};
          cpf_pkg::OFF_STS: rdata_ff <= {24'h00_0000, sts_ff & cpf_pkg::STS_MASK};
          default:          rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option register, freely programmable implemented bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dbg_ff <= cpf_pkg::DBG_RST;
    end else if (wr_en && aw_addr_ff == cpf_pkg::OFF_DBG) begin
      dbg_ff <= w_data_ff & cpf_pkg::DBG_MASK;
    end
  end

  // protection registers: a written 1 never sets a cleared bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdp_ff <= cpf_pkg::RDP_RST;
      bep_ff <= cpf_pkg::BEP_RST;
      wrp_ff <= cpf_pkg::WRP_RST;
    end else if (wr_en) begin
      if (aw_addr_ff == cpf_pkg::OFF_RDP) begin
        rdp_ff <= rdp_ff & w_data_ff & cpf_pkg::RDP_MASK;
      end
      if (aw_addr_ff == cpf_pkg::OFF_BEP) begin
        bep_ff <= bep_ff & w_data_ff & cpf_pkg::BEP_MASK;
      end
      if (aw_addr_ff == cpf_pkg::OFF_WRP) begin
        wrp_ff <= wrp_ff & w_data_ff & cpf_pkg::WRP_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack fault handling, set wins over the write-one clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sts_ff     <= cpf_pkg::STS_RST;
      stk_rst_ff <= 1'b0;
    end else begin
      stk_rst_ff <= stack_fault && dbg_ff[cpf_pkg::DBG_STK_BIT];
      if (stack_fault && !dbg_ff[cpf_pkg::DBG_STK_BIT]) begin
        sts_ff[cpf_pkg::STS_STACK_BIT] <= 1'b1;
      end else if (wr_en && aw_addr_ff == cpf_pkg::OFF_STS &&
                   w_data_ff[cpf_pkg::STS_STACK_BIT]) begin
        sts_ff[cpf_pkg::STS_STACK_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      opt_ff      <= '0;
      prot_ff     <= '0;
      dbg_pins_ff <= 1'b0;
    end else begin
      dbg_pins_ff                  <= !dbg_ff[cpf_pkg::DBG_DEBUGGER_BIT];
      opt_ff.debugger_on           <= !dbg_ff[cpf_pkg::DBG_DEBUGGER_BIT];
      opt_ff.extended_instr_en     <= dbg_ff[cpf_pkg::DBG_EXT_BIT];
      opt_ff.single_supply_prog_en <= dbg_ff[cpf_pkg::DBG_SSP_BIT];
      opt_ff.stack_fault_reset_en  <= dbg_ff[cpf_pkg::DBG_STK_BIT];
      prot_ff.blk_read_protect[1:0]  <= ~rdp_ff[1:0];
      prot_ff.blk_write_protect[1:0] <= ~wrp_ff[1:0];
      prot_ff.blk_read_protect[3:2]  <= SMALL_MEM ? 2'h0 : ~rdp_ff[3:2];
      prot_ff.blk_write_protect[3:2] <= SMALL_MEM ? 2'h0 : ~wrp_ff[3:2];
      prot_ff.eeprom_read_protect  <= !bep_ff[cpf_pkg::BEP_EEPROM_BIT];
      prot_ff.boot_read_protect    <= !bep_ff[cpf_pkg::BEP_BOOT_BIT];
    end
  end

  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign opt                  = opt_ff;
  assign prot                 = prot_ff;
  assign debug_pins_dedicated = dbg_pins_ff;
  assign stack_reset_req      = stk_rst_ff;
  assign stack_fault_flag     = sts_ff[cpf_pkg::STS_STACK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // outputs still hold reset zeros at the first edge after release
  property p_debug_pins;
    $past(rstn) |-> (debug_pins_dedicated == !$past(dbg_ff[7])) &&
                    (opt_ff.debugger_on == debug_pins_dedicated);
  endproperty
  a_debug_pins: assert property (p_debug_pins) else $error("debug pin ownership wrong");
  property p_ssp;
    $past(rstn) |-> opt_ff.single_supply_prog_en == $past(dbg_ff[2]);
  endproperty
  a_ssp: assert property (p_ssp) else $error("single supply enable wrong");
  property p_stack_reset;
    (stack_fault && dbg_ff[0]) |=> stack_reset_req;
  endproperty
  a_stack_reset: assert property (p_stack_reset) else $error("stack reset missing");
  property p_stack_flag;
    (stack_fault && !dbg_ff[0]) |=> (!stack_reset_req && stack_fault_flag);
  endproperty
  a_stack_flag: assert property (p_stack_flag) else $error("stack fault handled wrong");
  property p_unimpl;
    rvalid_ff |-> (rdata_ff[31:8] == 24'h00_0000);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits nonzero");
  property p_blk_read;
    $past(rstn) |-> prot_ff.blk_read_protect[1:0] == ~$past(rdp_ff[1:0]);
  endproperty
  a_blk_read: assert property (p_blk_read) else $error("block read protect wrong");
  property p_small_mem;
    $past(rstn) |-> prot_ff.blk_read_protect[3:2] == (SMALL_MEM ? 2'h0 : ~$past(rdp_ff[3:2])) &&
                    prot_ff.blk_write_protect[3:2] == (SMALL_MEM ? 2'h0 : ~$past(wrp_ff[3:2]));
  endproperty
  a_small_mem: assert property (p_small_mem) else $error("upper block protection wrong");
  property p_eeprom;
    $past(rstn) |-> prot_ff.eeprom_read_protect == !$past(bep_ff[7]);
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom protect wrong");
  property p_boot;
    $past(rstn) |-> prot_ff.boot_read_protect == !$past(bep_ff[6]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot protect wrong");
  property p_blk_write;
    $past(rstn) |-> prot_ff.blk_write_protect[1:0] == ~$past(wrp_ff[1:0]);
  endproperty
  a_blk_write: assert property (p_blk_write) else $error("block write protect wrong");
  property p_clear_only;
    $past(rstn) |-> ((rdp_ff & ~$past(rdp_ff)) == 8'h00) &&
                    ((bep_ff & ~$past(bep_ff)) == 8'h00) && ((wrp_ff & ~$past(wrp_ff)) == 8'h00);
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("protection bit was set");
  property p_unprog;
    !$past(rstn) |-> (dbg_ff == cpf_pkg::DBG_RST && rdp_ff == cpf_pkg::RDP_RST &&
                      bep_ff == cpf_pkg::BEP_RST && wrp_ff == cpf_pkg::WRP_RST);
  endproperty
  a_unprog: assert property (p_unprog) else $error("unprogrammed values wrong");

  property p_cov_write; wr_fire ##1 (bvalid_ff && s_axi_bready); endproperty
  c_cov_write: cover property (p_cov_write);
  property p_cov_read; ar_hs ##1 (rvalid_ff && s_axi_rready); endproperty
  c_cov_read: cover property (p_cov_read);
  property p_cov_stack; stack_fault ##1 stack_reset_req; endproperty
  c_cov_stack: cover property (p_cov_stack);
  property p_cov_protect;
    (wr_en && aw_addr_ff == cpf_pkg::OFF_RDP) ##1 (rdp_ff != cpf_pkg::RDP_RST);
  endproperty
  c_cov_protect: cover property (p_cov_protect);

endmodule // cpf_config_bank
`default_nettype wire

// *** core/cpf_pkg.sv ***
// package for the configuration and protection bank
// assumes a 32-bit axi4-lite master and byte-wide registers in lane 0
`default_nettype none
package cpf_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFF_DBG = 8'h00;
  localparam logic [7:0] OFF_RDP = 8'h04;
  localparam logic [7:0] OFF_BEP = 8'h08;
  localparam logic [7:0] OFF_WRP = 8'h0C;
  localparam logic [7:0] OFF_STS = 8'h10;

  // debug and stack options field positions
  localparam int unsigned DBG_DEBUGGER_BIT = 7;
  localparam int unsigned DBG_EXT_BIT      = 6;
  localparam int unsigned DBG_SSP_BIT      = 2;
  localparam int unsigned DBG_STK_BIT      = 0;
  // boot and eeprom field positions
  localparam int unsigned BEP_EEPROM_BIT   = 7;
  localparam int unsigned BEP_BOOT_BIT     = 6;
  // status field position
  localparam int unsigned STS_STACK_BIT    = 0;

  // implemented bits of each register
  localparam logic [7:0] DBG_MASK = 8'hC5;
  localparam logic [7:0] RDP_MASK = 8'h0F;
  localparam logic [7:0] BEP_MASK = 8'hC0;
  localparam logic [7:0] WRP_MASK = 8'h0F;
  localparam logic [7:0] STS_MASK = 8'h01;

  // unprogrammed values
  localparam logic [7:0] DBG_RST = 8'h85;
  localparam logic [7:0] RDP_RST = 8'h0F;
  localparam logic [7:0] BEP_RST = 8'hC0;
  localparam logic [7:0] WRP_RST = 8'h0F;
  localparam logic [7:0] STS_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // effective options driven to the core
  typedef struct packed {
    logic debugger_on;
    logic extended_instr_en;
    logic single_supply_prog_en;
    logic stack_fault_reset_en;
  } cpf_opt_t;

  // protection outputs, high means protected
  typedef struct packed {
    logic [3:0] blk_read_protect;
    logic       eeprom_read_protect;
    logic       boot_read_protect;
    logic [3:0] blk_write_protect;
  } cpf_prot_t;

endpackage
`default_nettype wire

// *** verification/test_config_protection_debug_fuses.sv ***
// self-checking bench for the configuration and protection bank
// assumes cpf_pkg and cpf_config_bank are compiled first; drives the axi4-lite port itself
`default_nettype none
module test_config_protection_debug_fuses;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk_sys = 1'b0;
  logic               rstn = 1'b0;
  logic [7:0]         s_axi_awaddr = 8'h00;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_awready;
  logic [31:0]        s_axi_wdata = 32'h0000_0000;
  logic [3:0]         s_axi_wstrb = 4'h0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready = 1'b0;
  logic [7:0]         s_axi_araddr = 8'h00;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_arready;
  logic [31:0]        s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready = 1'b0;
  logic               stack_full = 1'b0;
  logic               stack_underflow = 1'b0;
  cpf_pkg::cpf_opt_t  opt;
  cpf_pkg::cpf_prot_t prot;
  cpf_pkg::cpf_prot_t prot_small;
  logic               debug_pins_dedicated;
  logic               stack_reset_req;
  logic               stack_fault_flag;
  int                 errors = 0;
  int                 checked = 0;
  integer             seed = 32'hf369_b547;
  logic [7:0]         m_dbg, m_rdp, m_bep, m_wrp;

  always #10 clk_sys = ~clk_sys;

  cpf_config_bank i_dut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .stack_full(stack_full), .stack_underflow(stack_underflow),
    .opt(opt), .prot(prot), .debug_pins_dedicated(debug_pins_dedicated),
    .stack_reset_req(stack_reset_req), .stack_fault_flag(stack_fault_flag));

  // smaller part: same bus traffic, upper block bits must stay without effect
  cpf_config_bank #(.SMALL_MEM(1'b1)) i_dut_small (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .stack_full(stack_full), .stack_underflow(stack_underflow), .opt(), .prot(prot_small),
    .debug_pins_dedicated(), .stack_reset_req(), .stack_fault_flag());

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int   n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      n++;
      if (n > 50) begin
        errors++;
        summarize();
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
      if (n > 50) begin
        errors++;
        summarize();
      end
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rdata", {24'h00_0000, exp}, d);
    chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, r});
  endtask

  // registers read back, then core outputs against the model
  task automatic chk_all();
    chk_reg(cpf_pkg::OFF_DBG, m_dbg, cpf_pkg::RESP_OKAY);
    chk_reg(cpf_pkg::OFF_RDP, m_rdp, cpf_pkg::RESP_OKAY);
    chk_reg(cpf_pkg::OFF_BEP, m_bep, cpf_pkg::RESP_OKAY);
    chk_reg(cpf_pkg::OFF_WRP, m_wrp, cpf_pkg::RESP_OKAY);
    chk("opt", 32'({~m_dbg[7], m_dbg[6], m_dbg[2], m_dbg[0]}), 32'(opt));
    chk("pins", 32'({~m_dbg[7]}), 32'(debug_pins_dedicated));
    chk("prot_rd", 32'({~m_rdp[3:0]}), 32'(prot.blk_read_protect));
    chk("prot_ee", 32'({~m_bep[7]}), 32'(prot.eeprom_read_protect));
    chk("prot_bt", 32'({~m_bep[6]}), 32'(prot.boot_read_protect));
    chk("prot_wr", 32'({~m_wrp[3:0]}), 32'(prot.blk_write_protect));
    chk("small_rd", {28'h000_0000, 2'h0, ~m_rdp[1:0]}, 32'(prot_small.blk_read_protect));
    chk("small_wr", {28'h000_0000, 2'h0, ~m_wrp[1:0]}, 32'(prot_small.blk_write_protect));
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    m_dbg = 8'h85;
    m_rdp = 8'h0F;
    m_bep = 8'hC0;
    m_wrp = 8'h0F;
    repeat (2) @(negedge clk_sys);
  endtask

  // one-cycle stack fault; expects request or sticky flag by enable
  task automatic fault(input logic en);
    logic [1:0] r;
    wr(cpf_pkg::OFF_DBG, {7'h42, en}, 4'h1, r);
    m_dbg = {7'h42, en} & cpf_pkg::DBG_MASK;
    @(posedge clk_sys);
    stack_full <= en;
    stack_underflow <= ~en;
    @(posedge clk_sys);
    stack_full <= 1'b0;
    stack_underflow <= 1'b0;
    @(negedge clk_sys);
    chk("req", 32'(en), 32'(stack_reset_req));
    @(negedge clk_sys);
    chk("req_end", 32'h0000_0000, 32'(stack_reset_req));
    chk("flag", 32'({~en}), 32'(stack_fault_flag));
    if (!en) begin
      chk_reg(cpf_pkg::OFF_STS, 8'h01, cpf_pkg::RESP_OKAY);
      wr(cpf_pkg::OFF_STS, 8'h01, 4'h1, r);
      chk_reg(cpf_pkg::OFF_STS, 8'h00, cpf_pkg::RESP_OKAY);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end

  initial begin
    logic [7:0] a, d;
    logic [3:0] s;
    logic [1:0] r;
    int         k;
    for (int pass = 0; pass < 2; pass++) begin
      do_reset();
      chk_all();
      chk_reg(8'h14, 8'h00, cpf_pkg::RESP_SLVERR);
      wr(cpf_pkg::OFF_DBG, 8'h00, 4'h1, r);
      m_dbg = 8'h00;
      repeat (2) @(negedge clk_sys);
      chk_all();
      fault(1'b1);
      fault(1'b0);
      for (int i = 0; i < 24; i++) begin
        k = {$random(seed)} % 5;
        d = 8'($random(seed));
        s = 4'($random(seed));
        a = (k == 0) ? cpf_pkg::OFF_DBG : (k == 1) ? cpf_pkg::OFF_RDP :
            (k == 2) ? cpf_pkg::OFF_BEP : (k == 3) ? cpf_pkg::OFF_WRP : 8'h14;
        if (i < 2) begin
          s = 4'h1;
          d = 8'hFF;
        end
        wr(a, d, s, r);
        chk("bresp", 32'((k == 4) ? cpf_pkg::RESP_SLVERR : cpf_pkg::RESP_OKAY), 32'(r));
        if (s[0]) begin
          case (k)
            0: m_dbg = d & cpf_pkg::DBG_MASK;
            1: m_rdp = m_rdp & d;
            2: m_bep = m_bep & d;
            3: m_wrp = m_wrp & d;
            default: m_dbg = m_dbg;
          endcase
        end
        repeat (2) @(negedge clk_sys);
        chk_all();
      end
    end
    summarize();
  end
endmodule // test_config_protection_debug_fuses
`default_nettype wire
